// *** src/dacdec_defines.svh ***
// Constants for the input word decoder: widths, codes and reset values
`ifndef DACDEC_DEFINES_SVH
`define DACDEC_DEFINES_SVH

// ----------------------------------------------------------------------
// Word framing
// ----------------------------------------------------------------------
`define DACDEC_WORD_BITS      24
`define DACDEC_PEC_WORD_BITS  32
`define DACDEC_CNT_W          6
`define DACDEC_NUM_CHAN       4
`define DACDEC_SYNC_W         4

// ----------------------------------------------------------------------
// Register group select codes
// ----------------------------------------------------------------------
`define DACDEC_GRP_DATA       3'h0
`define DACDEC_GRP_GAIN       3'h2
`define DACDEC_GRP_GAIN_ALL   3'h3
`define DACDEC_GRP_OFS        3'h4
`define DACDEC_GRP_OFS_ALL    3'h5
`define DACDEC_GRP_CLR        3'h6
`define DACDEC_GRP_CTRL       3'h7

// ----------------------------------------------------------------------
// Control register select field and codes
// ----------------------------------------------------------------------
`define DACDEC_CSEL_MSB       15
`define DACDEC_CSEL_LSB       13
`define DACDEC_CDATA_MSB      12
`define DACDEC_CSEL_SLEW      3'h0
`define DACDEC_CSEL_MAIN      3'h1
`define DACDEC_CSEL_DACCTL    3'h2
`define DACDEC_CSEL_SUPPLY    3'h3
`define DACDEC_CSEL_SOFT      3'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DACDEC_CODE_RST       16'h0000
`define DACDEC_GAIN_RST       16'hffff
`define DACDEC_OFS_RST        16'h8000
`define DACDEC_CLR_RST        16'h0000

`endif

// *** src/dacdec_link_rx.sv ***
// Serial link receiver in the link clock domain
`timescale 1ns/10ps
`include "dacdec_defines.svh"

module dacdec_link_rx #(
  parameter int WORD_W = `DACDEC_WORD_BITS,
  parameter int PEC_W  = `DACDEC_PEC_WORD_BITS
) (
  input  wire logic              sclk_link,
  input  wire logic              rst_n,
  input  wire logic              sync_n,
  input  wire logic              sdin,
  input  wire logic              pec_enable,
  output logic      [WORD_W-1:0] word_out,
  output logic                   word_toggle
);

  logic [`DACDEC_CNT_W-1:0] cnt_reg;
  logic [`DACDEC_CNT_W-1:0] frame_len;
  logic [PEC_W-1:0]         shift_reg;
  logic [PEC_W-1:0]         shifted;
  logic                     pec_meta_reg;
  logic                     pec_reg;
  logic                     last_bit;

  // Link clock may stand still during reset, so reset acts without it
  always_ff @(posedge sclk_link or negedge rst_n) begin
    if (!rst_n) begin
      pec_meta_reg <= 1'b0;
      pec_reg      <= 1'b0;
    end else begin
      pec_meta_reg <= pec_enable;
      pec_reg      <= pec_meta_reg;
    end
  end

  assign frame_len = pec_reg ? `DACDEC_CNT_W'(PEC_W) : `DACDEC_CNT_W'(WORD_W);
  assign shifted   = {shift_reg[PEC_W-2:0], sdin};
  assign last_bit  = !sync_n && (cnt_reg == `DACDEC_CNT_W'(frame_len - 1'b1));

  // Frame select high ends the frame with no clock edge needed
  always_ff @(posedge sclk_link or posedge sync_n) begin
    if (sync_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg != frame_len) begin
      cnt_reg <= `DACDEC_CNT_W'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge sclk_link) begin
    if (!sync_n) begin
      shift_reg <= shifted;
    end
  end

  // Check code trails the word and is dropped here
  always_ff @(posedge sclk_link or negedge rst_n) begin
    if (!rst_n) begin
      word_out    <= '0;
      word_toggle <= 1'b0;
    end else if (last_bit) begin
      word_out    <= pec_reg ? shifted[PEC_W-1 -: WORD_W] : shifted[WORD_W-1:0];
      word_toggle <= ~word_toggle;
    end
  end

endmodule : dacdec_link_rx

// *** src/dacdec_pkg.sv ***
// Types shared by the input word decoder
package dacdec_pkg;

  typedef struct packed {
    logic        rw;
    logic        device_address_hi;
    logic        device_address_lo;
    logic [2:0]  register_group_select;
    logic        channel_select_hi;
    logic        channel_select_lo;
    logic [15:0] data;
  } dacdec_word_t;

  typedef struct packed {
    logic [15:0] output_code;
    logic [15:0] gain_trim;
    logic [15:0] offset_trim;
    logic [15:0] clear_value;
  } dacdec_chan_t;

  typedef struct packed {
    logic        write;
    logic [2:0]  control_register_select;
    logic        per_channel;
    logic [1:0]  channel;
    logic [12:0] data;
  } dacdec_ctrl_t;

  typedef enum logic [2:0] {
    DACDEC_ST_IDLE  = 3'h1,
    DACDEC_ST_CHECK = 3'h2,
    DACDEC_ST_APPLY = 3'h4
  } dacdec_state_t;

endpackage : dacdec_pkg

// *** src/dacdec_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/10ps

module dacdec_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      q          <= '0;
    end else begin
      stage1_reg <= d;
      q          <= stage1_reg;
    end
  end

endmodule : dacdec_sync

// *** src/dacdec_top.sv ***
// Input word decoder: per-channel code, trim and clear registers
`timescale 1ns/10ps
`include "dacdec_defines.svh"

// Operation
// - Word 24 bits, 32 with check code
// - Act only when address bits match pins
// - Group 000 loads addressed channel output code
// - Group 110 loads addressed channel clear value
// - Group 111 routes word to control registers
// - Control select bits 15..13 pick control register
// - Channel bits 00..11 select channels A..D
// - Channel bits ignored where meaningless
// - Group 010 writes addressed channel gain trim
// - Group 011 writes gain trim to all
// - Gain trim unsigned, resets to all ones
// - Group 100 writes addressed channel offset trim
// - Group 101 writes offset trim to all
// - Offset trim biased binary around 0x8000
// - Offset trim resets to mid-code
// - Clear value resets zero, drives output on clear
// - Per-channel enable for external clear response
module dacdec_top
  import dacdec_pkg::*;
#(
  parameter int NUM_CHAN = `DACDEC_NUM_CHAN
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         sclk_link,
  input  wire logic                         sync_n,
  input  wire logic                         sdin,
  input  wire logic                         pec_enable,
  input  wire logic                         address_pin_hi,
  input  wire logic                         address_pin_lo,
  input  wire logic                         clear_n,
  input  wire logic [NUM_CHAN-1:0]          clear_enable,
  output dacdec_chan_t [NUM_CHAN-1:0]       chan_regs,
  output dacdec_ctrl_t                      ctrl,
  output logic                              word_accepted,
  output logic                              word_ignored
);

  // ----------------------------------------------------------------------
  // Link side receiver
  // ----------------------------------------------------------------------
  logic [`DACDEC_WORD_BITS-1:0] rx_word;
  logic                         link_toggle;

  dacdec_link_rx #(
    .WORD_W (`DACDEC_WORD_BITS),
    .PEC_W  (`DACDEC_PEC_WORD_BITS)
  ) u_link_rx (
    .sclk_link   (sclk_link),
    .rst_n       (rst_n),
    .sync_n      (sync_n),
    .sdin        (sdin),
    .pec_enable  (pec_enable),
    .word_out    (rx_word),
    .word_toggle (link_toggle)
  );

  // ----------------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------------
  logic [`DACDEC_SYNC_W-1:0] sync_in;
  logic [`DACDEC_SYNC_W-1:0] sync_out;
  logic                      toggle_s;
  logic                      addr_hi_s;
  logic                      addr_lo_s;
  logic                      clear_n_s;

  // Clear goes in inverted so a flushed synchroniser reads as no clear
  assign sync_in = {link_toggle, address_pin_hi, address_pin_lo, ~clear_n};

  dacdec_sync #(
    .WIDTH (`DACDEC_SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (sync_in),
    .q       (sync_out)
  );

  assign toggle_s  = sync_out[3];
  assign addr_hi_s = sync_out[2];
  assign addr_lo_s = sync_out[1];
  assign clear_n_s = ~sync_out[0];

  // ----------------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------------
  function automatic logic [NUM_CHAN-1:0] chan_onehot(input logic [1:0] sel);
    chan_onehot = NUM_CHAN'(1) << sel;
  endfunction : chan_onehot

  function automatic logic [NUM_CHAN-1:0] chan_mask(input logic [2:0] grp,
                                                    input logic [1:0] sel);
    case (grp)
      `DACDEC_GRP_DATA,
      `DACDEC_GRP_GAIN,
      `DACDEC_GRP_OFS,
      `DACDEC_GRP_CLR:     chan_mask = chan_onehot(sel);
      `DACDEC_GRP_GAIN_ALL,
      `DACDEC_GRP_OFS_ALL: chan_mask = '1;
      default:             chan_mask = '0;
    endcase
  endfunction : chan_mask

  function automatic logic csel_known(input logic [2:0] csel);
    case (csel)
      `DACDEC_CSEL_SLEW,
      `DACDEC_CSEL_MAIN,
      `DACDEC_CSEL_DACCTL,
      `DACDEC_CSEL_SUPPLY,
      `DACDEC_CSEL_SOFT:   csel_known = 1'b1;
      default:             csel_known = 1'b0;
    endcase
  endfunction : csel_known

  function automatic logic csel_per_channel(input logic [2:0] csel);
    csel_per_channel = (csel == `DACDEC_CSEL_SLEW) || (csel == `DACDEC_CSEL_DACCTL);
  endfunction : csel_per_channel

  // ----------------------------------------------------------------------
  // Word capture sequence
  // ----------------------------------------------------------------------
  dacdec_state_t state_reg;
  dacdec_state_t state_next;
  dacdec_word_t  word_reg;
  logic          toggle_seen_reg;
  logic          new_word;

  assign new_word = toggle_s ^ toggle_seen_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DACDEC_ST_IDLE: begin
        if (new_word) begin
          state_next = DACDEC_ST_CHECK;
        end
      end
      DACDEC_ST_CHECK: state_next = DACDEC_ST_APPLY;
      DACDEC_ST_APPLY: state_next = DACDEC_ST_IDLE;
      default:         state_next = DACDEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= DACDEC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Held word is stable for a full frame after the toggle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      toggle_seen_reg <= 1'b0;
      word_reg        <= '0;
    end else if (state_reg == DACDEC_ST_IDLE && new_word) begin
      toggle_seen_reg <= toggle_s;
      word_reg        <= rx_word;
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  logic                addr_match;
  logic                is_write;
  logic                is_ctrl;
  logic [2:0]          csel;
  logic [1:0]          chan_sel;
  logic [NUM_CHAN-1:0] mask;
  logic                ctrl_hit;
  logic                accept;

  assign addr_match = {word_reg.device_address_hi, word_reg.device_address_lo}
                      == {addr_hi_s, addr_lo_s};
  assign is_write   = ~word_reg.rw;
  assign csel       = word_reg.data[`DACDEC_CSEL_MSB:`DACDEC_CSEL_LSB];
  assign chan_sel   = {word_reg.channel_select_hi, word_reg.channel_select_lo};
  assign is_ctrl    = word_reg.register_group_select == `DACDEC_GRP_CTRL;
  assign mask       = (addr_match && is_write) ? chan_mask(word_reg.register_group_select, chan_sel)
                                               : '0;
  assign ctrl_hit   = addr_match && is_write && is_ctrl && csel_known(csel);
  assign accept     = (|mask) || ctrl_hit;

  // ----------------------------------------------------------------------
  // Write enables, live for the apply cycle only
  // ----------------------------------------------------------------------
  logic [NUM_CHAN-1:0] we_code_reg;
  logic [NUM_CHAN-1:0] we_gain_reg;
  logic [NUM_CHAN-1:0] we_ofs_reg;
  logic [NUM_CHAN-1:0] we_clr_reg;
  logic [2:0]          grp;

  assign grp = word_reg.register_group_select;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_reg != DACDEC_ST_CHECK) begin
      we_code_reg <= '0;
      we_gain_reg <= '0;
      we_ofs_reg  <= '0;
      we_clr_reg  <= '0;
    end else begin
      we_code_reg <= (grp == `DACDEC_GRP_DATA) ? mask : '0;
      we_gain_reg <= (grp == `DACDEC_GRP_GAIN || grp == `DACDEC_GRP_GAIN_ALL) ? mask : '0;
      we_ofs_reg  <= (grp == `DACDEC_GRP_OFS || grp == `DACDEC_GRP_OFS_ALL) ? mask : '0;
      we_clr_reg  <= (grp == `DACDEC_GRP_CLR) ? mask : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------------
  logic clear_active;

  assign clear_active = ~clear_n_s;

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    logic [15:0] code_reg;
    logic [15:0] gain_reg;
    logic [15:0] ofs_reg;
    logic [15:0] clr_reg;

    // Clear level holds the output; data writes meanwhile are lost
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        code_reg <= `DACDEC_CODE_RST;
      end else if (clear_active && clear_enable[i]) begin
        code_reg <= clr_reg;
      end else if (we_code_reg[i]) begin
        code_reg <= word_reg.data;
      end
    end

    // Plain binary, no range limit enforced here
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        gain_reg <= `DACDEC_GAIN_RST;
      end else if (we_gain_reg[i]) begin
        gain_reg <= word_reg.data;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ofs_reg <= `DACDEC_OFS_RST;
      end else if (we_ofs_reg[i]) begin
        ofs_reg <= word_reg.data;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        clr_reg <= `DACDEC_CLR_RST;
      end else if (we_clr_reg[i]) begin
        clr_reg <= word_reg.data;
      end
    end

    assign chan_regs[i] = '{output_code: code_reg,
                            gain_trim:   gain_reg,
                            offset_trim: ofs_reg,
                            clear_value: clr_reg};
  end

  // ----------------------------------------------------------------------
  // Control register hand-off
  // ----------------------------------------------------------------------
  // One process owns the whole struct; write pulses, other fields hold the last routed word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl.write                   <= 1'b0;
      ctrl.control_register_select <= '0;
      ctrl.per_channel             <= 1'b0;
      ctrl.channel                 <= '0;
      ctrl.data                    <= '0;
    end else begin
      ctrl.write <= (state_reg == DACDEC_ST_CHECK) && ctrl_hit;
      if (state_reg == DACDEC_ST_CHECK && ctrl_hit) begin
        ctrl.control_register_select <= csel;
        ctrl.per_channel             <= csel_per_channel(csel);
        ctrl.channel                 <= csel_per_channel(csel) ? chan_sel : 2'h0;
        ctrl.data                    <= word_reg.data[`DACDEC_CDATA_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Word outcome pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_accepted <= 1'b0;
      word_ignored  <= 1'b0;
    end else begin
      word_accepted <= (state_reg == DACDEC_ST_CHECK) && accept;
      word_ignored  <= (state_reg == DACDEC_ST_CHECK) && !accept;
    end
  end

endmodule : dacdec_top

// *** tb/dacdec_host_model.sv ***
// Host side model driving the three-wire serial link
`timescale 1ns/10ps

module dacdec_host_model (
  output logic sclk_link,
  output logic sync_n,
  output logic sdin
);
  initial begin
    sclk_link = 1'b0;
    sync_n    = 1'b1;
    sdin      = 1'b0;
  end

  // Clock stands still between frames; data line toggles away once released
  task automatic send_frame(input logic [31:0] word, input int nbits, input realtime half);
    sync_n = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      sdin = word[i];
      #(half) sclk_link = 1'b1;
      #(half) sclk_link = 1'b0;
    end
    #(half) sync_n = 1'b1;
    sdin = ~sdin;
  endtask : send_frame
endmodule : dacdec_host_model

// *** tb/dacdec_top_assertions.sv ***
// Concurrent checks on the decoder top ports
`timescale 1ns/10ps

module dacdec_top_assertions
  import dacdec_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire logic                        sclk_link,
  input wire logic                        sync_n,
  input wire logic                        sdin,
  input wire logic                        pec_enable,
  input wire logic                        address_pin_hi,
  input wire logic                        address_pin_lo,
  input wire logic                        clear_n,
  input wire logic [NUM_CHAN-1:0]         clear_enable,
  input wire dacdec_chan_t [NUM_CHAN-1:0] chan_regs,
  input wire dacdec_ctrl_t                ctrl,
  input wire logic                        word_accepted,
  input wire logic                        word_ignored
);
  logic [NUM_CHAN*16-1:0] gain_all;
  logic [NUM_CHAN*16-1:0] ofs_all;
  logic [NUM_CHAN*16-1:0] clr_all;
  logic                   rst_ok;

  always_comb begin
    rst_ok = 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      gain_all[i*16 +: 16] = chan_regs[i].gain_trim;
      ofs_all[i*16 +: 16]  = chan_regs[i].offset_trim;
      clr_all[i*16 +: 16]  = chan_regs[i].clear_value;
      rst_ok = rst_ok && chan_regs[i].gain_trim == 16'hffff && chan_regs[i].offset_trim == 16'h8000
               && chan_regs[i].clear_value == 16'h0000 && chan_regs[i].output_code == 16'h0000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Sync delay of two edges, then one edge to load the code
  sequence s_clear_held;
    (!clear_n && clear_enable[0])[*4];
  endsequence

  property p_reset_vals;
    $rose(rst_n) |-> rst_ok && !word_accepted && !word_ignored && ctrl == '0;
  endproperty
  property p_gain_cause;
    $changed(gain_all) |-> $past(word_accepted);
  endproperty
  property p_ofs_cause;
    $changed(ofs_all) |-> $past(word_accepted);
  endproperty
  property p_clr_cause;
    $changed(clr_all) |-> $past(word_accepted);
  endproperty
  property p_ignored_quiet;
    word_ignored |=> $stable(gain_all) && $stable(ofs_all) && $stable(clr_all);
  endproperty
  property p_clear_out;
    s_clear_held |-> chan_regs[0].output_code == $past(chan_regs[0].clear_value);
  endproperty
  property p_code_cause;
    $changed(chan_regs[1].output_code) |-> $past(word_accepted) || $past(clear_enable[1]);
  endproperty
  property p_ctrl_write;
    ctrl.write |-> word_accepted && ctrl.control_register_select <= 3'h4;
  endproperty
  property p_excl;
    !(word_accepted && word_ignored);
  endproperty

  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_gain_cause: assert property (p_gain_cause) else $error("gain moved without word");
  a_ofs_cause: assert property (p_ofs_cause) else $error("offset moved without word");
  a_clr_cause: assert property (p_clr_cause) else $error("clear value moved without word");
  a_ignored_quiet: assert property (p_ignored_quiet) else $error("ignored word changed trim");
  a_clear_out: assert property (p_clear_out) else $error("clear did not load code");
  a_code_cause: assert property (p_code_cause) else $error("code moved without cause");
  a_ctrl_write: assert property (p_ctrl_write) else $error("bad control write");
  a_excl: assert property (p_excl) else $error("accepted and ignored together");
endmodule : dacdec_top_assertions

bind dacdec_top dacdec_top_assertions #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .sync_n(sync_n), .sdin(sdin),
  .pec_enable(pec_enable), .address_pin_hi(address_pin_hi), .address_pin_lo(address_pin_lo),
  .clear_n(clear_n), .clear_enable(clear_enable), .chan_regs(chan_regs), .ctrl(ctrl),
  .word_accepted(word_accepted), .word_ignored(word_ignored)
);

// *** tb/test_dacdec_top.sv ***
// Self-checking bench for the input word decoder
`timescale 1ns/10ps

module test_dacdec_top
  import dacdec_pkg::*;
;
  logic              clk_sys;
  logic              rst_n;
  logic              sclk_link;
  logic              sync_n;
  logic              sdin;
  logic              pec_enable;
  logic [1:0]        pins;
  logic              clear_n;
  logic [3:0]        clear_enable;
  dacdec_chan_t [3:0] chan_regs;
  dacdec_ctrl_t      ctrl;
  logic              word_accepted;
  logic              word_ignored;
  logic [15:0]       e_code [4];
  logic [15:0]       e_gain [4];
  logic [15:0]       e_ofs [4];
  logic [15:0]       e_clr [4];
  logic [23:0]       w;
  int                n_errors;
  int                total_checks;

  dacdec_top #(.NUM_CHAN(4)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .sync_n(sync_n), .sdin(sdin),
    .pec_enable(pec_enable), .address_pin_hi(pins[1]), .address_pin_lo(pins[0]), .clear_n(clear_n),
    .clear_enable(clear_enable), .chan_regs(chan_regs), .ctrl(ctrl), .word_accepted(word_accepted),
    .word_ignored(word_ignored)
  );
  dacdec_host_model host (.sclk_link(sclk_link), .sync_n(sync_n), .sdin(sdin));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic exp_acc(input logic [23:0] x);
    return !x[23] && x[22:21] == pins && x[20:18] != 3'h1 && !(x[20:18] == 3'h7 && x[15:13] > 3'h4);
  endfunction : exp_acc

  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      chk("output_code", {4'h0, e_code[i]}, {4'h0, chan_regs[i].output_code});
      chk("gain_trim", {4'h0, e_gain[i]}, {4'h0, chan_regs[i].gain_trim});
      chk("offset_trim", {4'h0, e_ofs[i]}, {4'h0, chan_regs[i].offset_trim});
      chk("clear_value", {4'h0, e_clr[i]}, {4'h0, chan_regs[i].clear_value});
    end
  endtask : check_all

  task automatic collect(output logic acc, output logic ign, output logic [19:0] cw);
    acc = 1'b0;
    ign = 1'b0;
    cw  = '0;
    for (int i = 0; i < 20 && acc !== 1'b1 && ign !== 1'b1; i++) begin
      @(negedge clk_sys);
      acc = word_accepted;
      ign = word_ignored;
      cw  = ctrl;
    end
  endtask : collect

  task automatic do_word(input logic [23:0] x, input logic slow);
    logic        acc;
    logic        ign;
    logic        ok;
    logic [19:0] cw;
    logic [19:0] ec;
    logic [2:0]  cs;
    ok = exp_acc(x);
    cs = x[15:13];
    host.send_frame({x, 8'h5a}, pec_enable ? 32 : 24, slow ? 40.0 : 7.5);
    collect(acc, ign, cw);
    chk("word_accepted", {19'h0, ok}, {19'h0, acc});
    chk("word_ignored", {19'h0, !ok}, {19'h0, ign});
    if (ok && x[20:18] == 3'h7) begin
      ec = {1'b1, cs, (cs == 3'h0 || cs == 3'h2), (cs == 3'h0 || cs == 3'h2) ? x[17:16] : 2'h0, x[12:0]};
      chk("ctrl", ec, cw);
    end
    for (int i = 0; i < 4; i++) begin
      if (ok && (i == x[17:16] || x[18])) begin
        case (x[20:18])
          3'h0: e_code[i] = x[15:0];
          3'h2, 3'h3: e_gain[i] = x[15:0];
          3'h4, 3'h5: e_ofs[i] = x[15:0];
          3'h6: e_clr[i] = x[15:0];
          default: ;
        endcase
      end
    end
    repeat (2) @(negedge clk_sys);
    check_all();
  endtask : do_word

  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end

  initial begin
    logic acc;
    logic ign;
    logic [19:0] cw;
    void'($urandom(54));
    rst_n = 1'b0;
    pec_enable = 1'b0;
    pins = 2'h2;
    clear_n = 1'b1;
    clear_enable = 4'h0;
    for (int i = 0; i < 4; i++) begin
      e_code[i] = 16'h0000;
      e_gain[i] = 16'hffff;
      e_ofs[i] = 16'h8000;
      e_clr[i] = 16'h0000;
    end
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1'b1;
    @(negedge clk_sys);
    check_all();
    // Every group code on every channel, then every control select
    for (int g = 0; g < 8; g++) begin
      for (int c = 0; c < 4; c++) begin
        do_word({1'b0, pins, 3'(g), 2'(c), 16'($urandom())}, c[0]);
      end
    end
    for (int k = 0; k < 8; k++) begin
      do_word({1'b0, pins, 3'h7, 2'($urandom()), 3'(k), 13'($urandom())}, k[0]);
    end
    for (int n = 0; n < 40; n++) begin
      if (n % 8 == 0) pins = 2'($urandom());
      w = 24'($urandom());
      w[23] = ($urandom_range(7) == 0);
      if ($urandom_range(3) != 0) w[22:21] = pins;
      if (w[20:19] == 2'h1) w[15] = 1'b1;
      do_word(w, 1'($urandom()));
    end
    // Aborted frame also carries the new framing length across
    pec_enable = 1'b1;
    host.send_frame(32'hffff_ffff, 4, 7.5);
    collect(acc, ign, cw);
    chk("aborted frame", 20'h0_0000, {18'h0, acc, ign});
    for (int n = 0; n < 4; n++) begin
      do_word({1'b0, pins, 3'(2 * n), 2'(n), 16'($urandom())}, 1'b0);
    end
    pec_enable = 1'b0;
    host.send_frame(32'h0000_0000, 4, 7.5);
    collect(acc, ign, cw);
    chk("aborted frame", 20'h0_0000, {18'h0, acc, ign});
    clear_enable = 4'h5;
    clear_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      if (clear_enable[i]) e_code[i] = e_clr[i];
    end
    check_all();
    clear_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    do_word({1'b0, pins, 3'h0, 2'h2, 16'ha5a5}, 1'b0);
    stop_test();
  end
endmodule : test_dacdec_top
